// ---- verif/csem_pm_model.sv ----
/*
 * Power management status held on the host side of the function.
 * Assumes the same clock and reset as the status change logic.
 */
`timescale 1ns/100ps

module csem_pm_model
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic wake_source,
   input  wire logic pme_status_w1c,
   input  wire logic pme_status_clr,
   output logic      pme_status,
   output int        clr_cycles
);
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         pme_status <= 1'h0;
         clr_cycles <= 0;
      end
      else
      begin
         // cycles of the clear pulse, to see that it stands one cycle
         if (pme_status_clr)
            clr_cycles <= clr_cycles + 1;
         pme_status <= wake_source
                       | (pme_status & !pme_status_clr & !pme_status_w1c);
      end
endmodule

// ---- verif/testbench.sv ----
/*
 * Self-checking bench for the status change event and mask logic.
 * Assumes csem_pkg and csem_map.svh compiled first.
 */
`timescale 1ns/100ps

module testbench;
   import csem_pkg::*;
   logic       clk = 1'h0;
   logic       arst_n = 1'h0;
   logic       ce = 1'h1;
   logic       csr_wr = 1'h0;
   logic       csr_rd = 1'h0;
   csem_addr_t csr_addr = 8'h00;
   csem_word_t csr_wdata = 32'h00000000;
   csem_word_t csr_rdata;
   logic       interrupt_event_bit_source = 1'h0;
   logic       wake_source = 1'h0;
   logic       scb_int_enable = 1'h0;
   logic       pme_enable = 1'h0;
   logic       pme_status_w1c = 1'h0;
   logic       inta_req, cstschg, pme_status_clr, pme_status;
   int         clr_cycles, i, n;
   int         mismatches = 0;
   int         samples_checked = 0;
   logic [31:0] seed = 32'hBDEAF742;
   csem_word_t exp_q[$];

   always #25 clk = ~clk;

   csem_status_change dut (.clk, .arst_n, .ce, .csr_wr, .csr_rd, .csr_addr,
      .csr_wdata, .csr_rdata, .interrupt_event_bit_source, .wake_source, .scb_int_enable,
      .pme_enable, .pme_status_w1c, .inta_req, .cstschg, .pme_status_clr);
   csem_pm_model pm (.clk, .arst_n, .wake_source, .pme_status_w1c,
      .pme_status_clr, .pme_status, .clr_cycles);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr(csem_addr_t a, csem_word_t d);
      @(posedge clk);
      csr_wr <= 1'h1;
      csr_addr <= a;
      csr_wdata <= d;
      @(posedge clk);
      csr_wr <= 1'h0;
   endtask

   task automatic rd(csem_addr_t a, csem_word_t e);
      @(posedge clk);
      csr_rd <= 1'h1;
      csr_addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      csr_rd <= 1'h0;
   endtask

   // read data compared half a cycle after the taking edge
   always @(posedge clk)
      if (csr_rd === 1'h1)
      begin
         @(negedge clk);
         chk("csr_rdata", exp_q.pop_front(), csr_rdata);
      end

   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #1000000;
      mismatches++;
      results();
   end

   initial
   begin
      tick(12);
      arst_n <= 1'h1;
      rd(8'h30, 32'h00000000);
      rd(8'h34, 32'h00000000);
      // clock enable low: the write must be ignored
      ce <= 1'h0;
      wr(8'h34, 32'hFFFFFFFF);
      ce <= 1'h1;
      rd(8'h34, 32'h00000000);
      repeat (4)
      begin
         csr_wdata <= rnd();
         #1;
         wr(8'h34, csr_wdata);
         rd(8'h34, csr_wdata & 32'h0000C070);
      end
      wr(8'h38, 32'hFFFFFFFF);
      rd(8'h38, 32'h00000000);
      wr(8'h34, 32'h00008000);
      @(posedge clk);
      interrupt_event_bit_source <= 1'h1;
      scb_int_enable <= 1'h1;
      tick(3);
      chk("inta_req", 32'(inta_req), 32'h1);
      scb_int_enable <= 1'h0;
      tick(3);
      chk("inta_req", 32'(inta_req), 32'h0);
      scb_int_enable <= 1'h1;
      wr(8'h34, 32'h00000000);
      tick(3);
      chk("inta_req", 32'(inta_req), 32'h0);
      rd(8'h30, 32'h00008000);
      wr(8'h34, 32'h00008000);
      wr(8'h30, 32'h00008000);
      rd(8'h30, 32'h00008000);
      @(posedge clk);
      interrupt_event_bit_source <= 1'h0;
      wr(8'h30, 32'h00000000);
      rd(8'h30, 32'h00008000);
      wr(8'h30, 32'hFFFFFFFF);
      rd(8'h30, 32'h00000000);
      tick(3);
      chk("inta_req", 32'(inta_req), 32'h0);
      // the all-ones write above already gave one clear pulse
      n = 1;
      for (i = 0; i < 8; i++)
      begin
         wr(8'h34, {16'h0000, 1'h0, i[0], 9'h000, i[1], 4'h0});
         pme_enable <= i[2];
         wake_source <= 1'h1;
         @(posedge clk);
         wake_source <= 1'h0;
         tick(3);
         chk("cstschg", 32'(cstschg), 32'(i[2] | (i[0] & i[1])));
         rd(8'h30, 32'h00000010);
         if (i[0])
            wr(8'h30, 32'h00000010);
         else
         begin
            @(posedge clk);
            pme_status_w1c <= 1'h1;
            @(posedge clk);
            pme_status_w1c <= 1'h0;
         end
         n += i[0];
         tick(3);
         chk("cstschg", 32'(cstschg), 32'h0);
         chk("pme_status", 32'(pme_status), 32'h0);
         chk("clr_cycles", 32'(clr_cycles), 32'(n));
         rd(8'h30, 32'h00000000);
      end
      @(posedge clk);
      wake_source <= 1'h1;
      wr(8'h30, 32'h00000010);
      rd(8'h30, 32'h00000010);
      tick(2);
      results();
   end
endmodule

// ---- verilog/csem_event_latch.sv ----
/*
 * One sticky event bit: set by hardware, cleared by a qualified write.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps

module csem_event_latch
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);
   import csem_pkg::*;

   csem_latch_st_t st_q;
   csem_latch_st_t st_d;

   always_comb
   begin
      st_d = st_q;
      // set beats a clear in the same cycle
      st_d.bit_q = set | (st_q.bit_q & ~clr);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         st_q <= '0;
      else if (ce)
         st_q <= st_d;
   end

   assign q = st_q.bit_q;

endmodule

// ---- verilog/csem_map.svh ----
/*
 * Register offsets, field positions and reset values of the card status
 * change event and mask registers of the network function.
 * Assumes inclusion by the package and the modules that decode accesses.
 */
`ifndef CSEM_MAP_SVH
`define CSEM_MAP_SVH

`define CSEM_GROUP_BASE   8'h30
`define CSEM_EVENT_OFF    8'h30
`define CSEM_MASK_OFF     8'h34

`define CSEM_INTERRUPT_EVENT_BIT_POS     15
`define CSEM_WAKE_SIGNAL_MASK_POS     14
`define CSEM_AUDIO_HI     6
`define CSEM_AUDIO_LO     5
`define CSEM_GENERAL_WAKE_BIT_POS    4

`define CSEM_REG_RESET    32'h00000000
`define CSEM_BIT_CLEAR    1'h0
`define CSEM_AUDIO_RESET  2'h0

`endif

// ---- verilog/csem_pkg.sv ----
/*
 * Types shared by the card status change event and mask logic.
 * Assumes csem_map.svh is on the include path.
 */
`include "csem_map.svh"

package csem_pkg;

   typedef logic [7:0]  csem_addr_t;
   typedef logic [31:0] csem_word_t;

   typedef struct packed {
      logic bit_q;
   } csem_latch_st_t;

   typedef struct packed {
      logic       interrupt_event_bit_mask_q;
      logic       wake_signal_mask_mask_q;
      logic [1:0] audio_q;
      logic       general_wake_bit_mask_q;
      csem_word_t rdata_q;
      logic       inta_q;
      logic       cstschg_q;
      logic       pme_clr_q;
   } csem_state_t;

endpackage

// ---- verilog/csem_status_change.sv ----
/*
 * Card status change event and mask registers of the network function,
 * with gating of the interrupt request and of the status change signal.
 * Assumes a same-clock register port inside the control/status space,
 * event sources and enables driven by logic on clk, and arst_n being
 * the alternate power-on reset only.
 */
`timescale 1ns/100ps

`include "csem_map.svh"

// Behaviour
// - interrupt event bit 15 sets whenever interrupt source active, mask ignored.
// - bit 15 clears on write-one only once source serviced; zero writes ignored.
// - general wake bit 4 sets whenever wake source active, mask ignored.
// - write-one to bit 4 clears it and the power management status.
// - write-one to power management status also clears general wake bit.
// - event bits 31:16, 14:5, 3:0 reserved, read zero.
// - interrupt mask bit 15 low keeps interrupt request inactive.
// - interrupt request only when mask bit and control block enable set.
// - wake mask bit 14 low suppresses status change unless PME enable set, event kept.
// - wake mask bit 14 works together with general wake mask bit 4.
// - general wake mask bit 4 low blocks wake toward status change unless PME enable set.
// - status change when wake event and (both masks or PME enable).
// - mask bits 6:5 audio field unused; 31:16, 13:7, 3:0 reserved.
// - combined card has two separate register sets, one per function.
// - only the alternate power-on reset initialises these registers.
module csem_status_change
(
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          ce,
   input  wire logic          csr_wr,
   input  wire logic          csr_rd,
   input  csem_pkg::csem_addr_t csr_addr,
   input  csem_pkg::csem_word_t csr_wdata,
   output csem_pkg::csem_word_t csr_rdata,
   input  wire logic          interrupt_event_bit_source,
   input  wire logic          wake_source,
   input  wire logic          scb_int_enable,
   input  wire logic          pme_enable,
   input  wire logic          pme_status_w1c,
   output logic               inta_req,
   output logic               cstschg,
   output logic               pme_status_clr
);
   import csem_pkg::*;

   csem_state_t st_q;
   csem_state_t st_d;
   logic        interrupt_event_bit_bit;
   logic        general_wake_bit_bit;
   logic        wr_event;
   logic        wr_mask;
   logic        clr_interrupt_event_bit;
   logic        clr_general_wake_bit;

   function automatic logic hit(input csem_addr_t a, input csem_addr_t off);
      hit = (a == off);
   endfunction

   assign wr_event  = csr_wr & hit(csr_addr, `CSEM_EVENT_OFF);
   assign wr_mask   = csr_wr & hit(csr_addr, `CSEM_MASK_OFF);
   // serviced means the source has dropped
   assign clr_interrupt_event_bit  = wr_event & csr_wdata[`CSEM_INTERRUPT_EVENT_BIT_POS]
                      & ~interrupt_event_bit_source;
   assign clr_general_wake_bit = (wr_event & csr_wdata[`CSEM_GENERAL_WAKE_BIT_POS])
                      | pme_status_w1c;

   // one latch pair per function; a modem function gets its own instance
   csem_event_latch u_interrupt_event_bit
   (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .set    (interrupt_event_bit_source),
      .clr    (clr_interrupt_event_bit),
      .q      (interrupt_event_bit_bit)
   );

   csem_event_latch u_general_wake_bit
   (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .set    (wake_source),
      .clr    (clr_general_wake_bit),
      .q      (general_wake_bit_bit)
   );

   always_comb
   begin
      st_d = st_q;
      if (wr_mask)
      begin
         st_d.interrupt_event_bit_mask_q  = csr_wdata[`CSEM_INTERRUPT_EVENT_BIT_POS];
         st_d.wake_signal_mask_mask_q  = csr_wdata[`CSEM_WAKE_SIGNAL_MASK_POS];
         // stored for readback only, no effect here
         st_d.audio_q      = csr_wdata[`CSEM_AUDIO_HI:`CSEM_AUDIO_LO];
         st_d.general_wake_bit_mask_q = csr_wdata[`CSEM_GENERAL_WAKE_BIT_POS];
      end
      if (csr_rd)
      begin
         st_d.rdata_q = `CSEM_REG_RESET;
         if (hit(csr_addr, `CSEM_EVENT_OFF))
         begin
            st_d.rdata_q[`CSEM_INTERRUPT_EVENT_BIT_POS]  = interrupt_event_bit_bit;
            st_d.rdata_q[`CSEM_GENERAL_WAKE_BIT_POS] = general_wake_bit_bit;
         end
         else if (hit(csr_addr, `CSEM_MASK_OFF))
         begin
            st_d.rdata_q[`CSEM_INTERRUPT_EVENT_BIT_POS]  = st_q.interrupt_event_bit_mask_q;
            st_d.rdata_q[`CSEM_WAKE_SIGNAL_MASK_POS]  = st_q.wake_signal_mask_mask_q;
            st_d.rdata_q[`CSEM_AUDIO_HI:`CSEM_AUDIO_LO] = st_q.audio_q;
            st_d.rdata_q[`CSEM_GENERAL_WAKE_BIT_POS] = st_q.general_wake_bit_mask_q;
         end
      end
      st_d.inta_q = interrupt_event_bit_bit & st_q.interrupt_event_bit_mask_q
                    & scb_int_enable;
      st_d.cstschg_q = general_wake_bit_bit
                       & ((st_q.wake_signal_mask_mask_q & st_q.general_wake_bit_mask_q)
                          | pme_enable);
      st_d.pme_clr_q = wr_event & csr_wdata[`CSEM_GENERAL_WAKE_BIT_POS];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q              <= '0;
         st_q.interrupt_event_bit_mask_q  <= `CSEM_BIT_CLEAR;
         st_q.wake_signal_mask_mask_q  <= `CSEM_BIT_CLEAR;
         st_q.audio_q      <= `CSEM_AUDIO_RESET;
         st_q.general_wake_bit_mask_q <= `CSEM_BIT_CLEAR;
         st_q.rdata_q      <= `CSEM_REG_RESET;
      end
      else if (ce)
         st_q <= st_d;
   end

   assign csr_rdata      = st_q.rdata_q;
   assign inta_req       = st_q.inta_q;
   assign cstschg        = st_q.cstschg_q;
   assign pme_status_clr = st_q.pme_clr_q;

   interrupt_event_bit_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && interrupt_event_bit_source |=> interrupt_event_bit_bit)
      else $error("interrupt event bit not set by source");

   interrupt_event_bit_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && interrupt_event_bit_bit && interrupt_event_bit_source |=> interrupt_event_bit_bit)
      else $error("interrupt event bit cleared while source active");

   general_wake_bit_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wake_source |=> general_wake_bit_bit)
      else $error("wake event bit not set by source");

   general_wake_bit_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_event && csr_wdata[`CSEM_GENERAL_WAKE_BIT_POS] && !wake_source
      |=> !general_wake_bit_bit && pme_status_clr)
      else $error("wake clear write had no effect");

   pme_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && pme_status_w1c && !wake_source |=> !general_wake_bit_bit)
      else $error("power status clear left wake bit set");

   rsvd_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
      $past(csr_rd) |-> csr_rdata[31:16] == 16'h0000
      && csr_rdata[3:0] == 4'h0 && csr_rdata[13:7] == 7'h00)
      else $error("reserved read bits not zero");

   inta_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce ##1 inta_req |-> $past(interrupt_event_bit_bit) && $past(st_q.interrupt_event_bit_mask_q)
      && $past(scb_int_enable))
      else $error("interrupt request without its enables");

   inta_masked_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && !st_q.interrupt_event_bit_mask_q |=> !inta_req)
      else $error("masked interrupt request asserted");

   stschg_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce |=> cstschg == ($past(general_wake_bit_bit) && (($past(st_q.wake_signal_mask_mask_q)
      && $past(st_q.general_wake_bit_mask_q)) || $past(pme_enable))))
      else $error("status change output wrong");

   set_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wake_source && clr_general_wake_bit |=> general_wake_bit_bit)
      else $error("event lost against clear");

   mask_rb_a: assert property (@(posedge clk) disable iff (!arst_n)
      ce && wr_mask ##1 ce && !wr_mask ##1 ce && csr_rd
      && hit(csr_addr, `CSEM_MASK_OFF) && !wr_mask
      |=> csr_rdata[`CSEM_WAKE_SIGNAL_MASK_POS]
      == $past(csr_wdata[`CSEM_WAKE_SIGNAL_MASK_POS], 3))
      else $error("mask readback mismatch");

endmodule
